// ===== design/sdo_byte_order.sv
// Places a value into the four data bytes in the selected byte order
`timescale 1ns/100ps
module sdo_byte_order
   import sdo_pkg::*;
(
   // Value
   input  wire logic [31:0] i_value,
   input  wire logic        i_two_bytes,
   input  wire logic        i_msb_first,
   // Bytes 4..7 of the frame, byte 4 in [7:0]
   output logic      [31:0] o_bytes
);
   logic [31:0] le;

   always_comb begin
      le = i_two_bytes ? {16'h0000, i_value[15:0]} : i_value;
      if (!i_msb_first) begin
         o_bytes = le;
      end else if (i_two_bytes) begin
         o_bytes = {16'h0000, i_value[7:0], i_value[15:8]};
      end else begin
         o_bytes = {i_value[7:0], i_value[15:8],
                    i_value[23:16], i_value[31:24]};
      end
   end
endmodule // sdo_byte_order

// ===== design/sdo_int_shape.sv
// Decimal shift, clamping and narrowing of integer process values
`timescale 1ns/100ps
module sdo_int_shape
   import sdo_pkg::*;
(
   // Raw integer process value and settings
   input  wire logic signed [31:0] i_value,
   input  wire logic        [2:0]  i_dec_shift,
   input  wire logic               i_clamp_en,
   input  wire logic signed [31:0] i_min,
   input  wire logic signed [31:0] i_max,
   // Shaped values
   output logic signed      [31:0] o_int32,
   output logic signed      [15:0] o_int16
);
   logic signed [31:0] shifted;
   logic signed [31:0] clamped;

   function automatic logic signed [31:0] times_ten(
      input logic signed [31:0] v);
      times_ten = (v <<< 3) + (v <<< 1);
   endfunction

   always_comb begin
      shifted = i_value;
      for (int k = 0; k < DEC_SHIFT_MAX; k++) begin
         if (k < int'(i_dec_shift)) begin
            shifted = times_ten(shifted);
         end
      end
      clamped = shifted;
      if (i_clamp_en && shifted < i_min) begin
         clamped = i_min;
      end else if (i_clamp_en && shifted > i_max) begin
         clamped = i_max;
      end
      o_int32 = clamped;
      if (clamped > 32'sd32767) begin
         o_int16 = 16'sh7FFF;
      end else if (clamped < -32'sd32768) begin
         o_int16 = 16'sh8000;
      end else begin
         o_int16 = clamped[15:0];
      end
   end
endmodule // sdo_int_shape

// ===== design/sdo_pkg.sv
// Constants and types of the object access responder
package sdo_pkg;
   localparam logic [10:0] COB_RX_BASE    = 11'h600;
   localparam logic [10:0] COB_TX_BASE    = 11'h580;
   localparam logic [7:0]  CMD_UPLOAD_REQ = 8'h40;
   localparam logic [7:0]  CMD_UPLOAD_4B  = 8'h43;
   localparam logic [7:0]  CMD_DNLOAD_4B  = 8'h23;
   localparam logic [7:0]  CMD_DNLOAD_ACK = 8'h60;
   localparam logic [7:0]  CMD_ABORT      = 8'h80;
   localparam logic [15:0] OBJ_STARTUP    = 16'h1F80;
   localparam logic [15:0] OBJ_PV_FLOAT   = 16'h6130;
   localparam logic [15:0] OBJ_DEC_DIGITS = 16'h6132;
   localparam logic [15:0] OBJ_FV_INT16   = 16'h7100;
   localparam logic [15:0] OBJ_PV_INT16   = 16'h7130;
   localparam logic [15:0] OBJ_PV_INT32   = 16'h9130;
   localparam logic [7:0]  SUB_PRIMARY    = 8'h01;
   localparam logic [7:0]  SUB_SECONDARY  = 8'h02;
   localparam logic [7:0]  STARTUP_AUTO   = 8'h08;
   localparam logic [7:0]  STARTUP_OFF    = 8'h00;
   localparam logic [7:0]  STARTUP_RESET  = 8'h00;
   localparam logic [31:0] ABORT_NO_OBJ   = 32'h0602_0000;
   localparam logic [31:0] ABORT_NO_SUB   = 32'h0609_0011;
   localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
   localparam logic [31:0] ABORT_BAD_VAL  = 32'h0609_0030;
   localparam logic [31:0] ABORT_BAD_CMD  = 32'h0504_0001;
   localparam logic [15:0] RANGE_FULL     = 16'h4E20;
   localparam logic [31:0] RANGE_FULL_F   = 32'h469C_4000;
   localparam int          DEC_SHIFT_MAX  = 4;

   typedef struct packed {
      logic [10:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
   } can_frame_s;

   typedef struct packed {
      logic [31:0] pv_float;
      logic [31:0] pv_int;
      logic [15:0] fv_int16;
   } chan_value_s;
endpackage

// ===== design/sdo_responder.sv
// Expedited object access responder for the sensor node
`timescale 1ns/100ps
module sdo_responder
   import sdo_pkg::*;
#(
   parameter logic HAS_SECONDARY = 1'b1
)(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   // Node settings
   input  wire logic        [6:0] i_node_id,
   input  wire logic              i_msb_first,
   input  wire logic        [2:0] i_dec_shift,
   input  wire logic              i_clamp_en,
   input  wire logic signed [31:0] i_clamp_min,
   input  wire logic signed [31:0] i_clamp_max,
   input  wire logic              i_boot_done,
   // Measurements already scaled to the user range
   input  wire chan_value_s       i_chan1,
   input  wire chan_value_s       i_chan2,
   // Received frame
   input  wire can_frame_s        i_rx_frame,
   input  wire logic              i_rx_valid,
   // Transmitted frame
   output can_frame_s             o_tx_frame,
   output logic                   o_tx_valid,
   input  wire logic              i_tx_ready,
   // Start-up and network state
   output logic                   o_autostart,
   output logic                   o_operational,
   output logic                   o_pdo_enable
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_BOOT = 3'b100
   } state_e;

   state_e      state;
   state_e      next_state;
   can_frame_s  tx_frame;
   can_frame_s  next_tx_frame;
   logic        autostart;
   logic        next_autostart;
   logic        operational;
   logic        next_operational;

   logic [7:0]  rx_cmd;
   logic [15:0] rx_index;
   logic [7:0]  rx_sub;
   logic [31:0] rx_data;
   logic        for_me;
   logic        sub_ok;
   chan_value_s chan;
   logic [31:0] shaped32;
   logic [15:0] shaped16;
   logic [31:0] up_value;
   logic        up_two;
   logic [31:0] up_bytes;

   function automatic logic [63:0] pack_reply(
      input logic [7:0]  cmd,
      input logic [15:0] index,
      input logic [7:0]  sub,
      input logic [31:0] data);
      pack_reply = {data, sub, index[15:8], index[7:0], cmd};
   endfunction

   // Frame fields, byte 0 sits in the low bits
   assign rx_cmd   = i_rx_frame.data[7:0];
   assign rx_index = {i_rx_frame.data[23:16], i_rx_frame.data[15:8]};
   assign rx_sub   = i_rx_frame.data[31:24];
   assign rx_data  = i_rx_frame.data[63:32];
   assign for_me   = i_rx_valid && i_rx_frame.id ==
                     (COB_RX_BASE + {4'h0, i_node_id});
   assign sub_ok   = rx_sub == SUB_PRIMARY ||
                     (HAS_SECONDARY && rx_sub == SUB_SECONDARY);
   // Channels arrive already mapped onto the digital span
   assign chan     = (rx_sub == SUB_SECONDARY) ? i_chan2 : i_chan1;

   sdo_int_shape u_shape (
      .i_value    (chan.pv_int),
      .i_dec_shift(i_dec_shift),
      .i_clamp_en (i_clamp_en),
      .i_min      (i_clamp_min),
      .i_max      (i_clamp_max),
      .o_int32    (shaped32),
      .o_int16    (shaped16)
   );

   always_comb begin
      up_two   = 1'b0;
      up_value = chan.pv_float;
      unique case (rx_index)
         OBJ_PV_INT16: begin
            up_two   = 1'b1;
            up_value = {16'h0000, shaped16};
         end
         OBJ_PV_INT32: up_value = shaped32;
         OBJ_FV_INT16: begin
            up_two   = 1'b1;
            up_value = {16'h0000, chan.fv_int16};
         end
         default: up_value = chan.pv_float;
      endcase
   end

   sdo_byte_order u_order (
      .i_value    (up_value),
      .i_two_bytes(up_two),
      .i_msb_first(i_msb_first),
      .o_bytes    (up_bytes)
   );

   always_comb begin
      next_state       = state;
      next_tx_frame    = tx_frame;
      next_autostart   = autostart;
      next_operational = operational;
      unique case (state)
         ST_BOOT: begin
            if (i_boot_done) begin
               next_operational = autostart;
               next_state       = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (!i_boot_done) begin
               // Firmware restart keeps the volatile setting
               next_operational = 1'b0;
               next_state       = ST_BOOT;
            end else if (for_me) begin
               next_state       = ST_SEND;
               next_tx_frame.id = COB_TX_BASE + {4'h0, i_node_id};
               next_tx_frame.dlc = 4'h8;
               next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                                               rx_sub, ABORT_NO_OBJ);
               if (rx_index == OBJ_STARTUP) begin
                  if (rx_sub != 8'h00) begin
                     next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                        rx_sub, ABORT_NO_SUB);
                  end else if (rx_cmd == CMD_UPLOAD_REQ) begin
                     next_tx_frame.data = pack_reply(CMD_UPLOAD_4B,
                        rx_index, rx_sub, {24'h000000, autostart ?
                        STARTUP_AUTO : STARTUP_OFF});
                  end else if (rx_cmd != CMD_DNLOAD_4B) begin
                     next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                        rx_sub, ABORT_BAD_CMD);
                  end else if (rx_data == {24'h000000, STARTUP_AUTO} ||
                               rx_data == {24'h000000, STARTUP_OFF}) begin
                     // Volatile only, lost at reset
                     next_autostart = rx_data[7:0] == STARTUP_AUTO;
                     next_tx_frame.data = pack_reply(CMD_DNLOAD_ACK,
                        rx_index, rx_sub, 32'h0000_0000);
                  end else begin
                     next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                        rx_sub, ABORT_BAD_VAL);
                  end
               end else if (rx_index == OBJ_PV_FLOAT ||
                            rx_index == OBJ_PV_INT16 ||
                            rx_index == OBJ_PV_INT32 ||
                            rx_index == OBJ_FV_INT16) begin
                  if (!sub_ok) begin
                     next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                        rx_sub, ABORT_NO_SUB);
                  end else if (rx_cmd == CMD_UPLOAD_REQ) begin
                     next_tx_frame.data = pack_reply(CMD_UPLOAD_4B,
                        rx_index, rx_sub, up_bytes);
                  end else begin
                     next_tx_frame.data = pack_reply(CMD_ABORT, rx_index,
                        rx_sub, ABORT_READ_ONLY);
                  end
               end
            end
         end
         ST_SEND: begin
            if (i_tx_ready) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_BOOT;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state       <= ST_BOOT;
         tx_frame    <= '0;
         autostart   <= 1'b0;
         operational <= 1'b0;
      end else begin
         state       <= next_state;
         tx_frame    <= next_tx_frame;
         autostart   <= next_autostart;
         operational <= next_operational;
      end
   end

   assign o_tx_frame    = tx_frame;
   assign o_tx_valid    = state == ST_SEND;
   assign o_autostart   = autostart;
   assign o_operational = operational;
   assign o_pdo_enable  = operational;

   // Request accepted at this edge
   logic        req_taken;
   assign req_taken = state == ST_IDLE && i_boot_done && for_me;

   a_startup_ack: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_index == OBJ_STARTUP &&
      rx_sub == 8'h00 && rx_cmd == CMD_DNLOAD_4B &&
      rx_data == 32'h0000_0008
      |=> o_tx_valid && o_tx_frame.data[7:0] == 8'h60 &&
          o_tx_frame.data[63:32] == 32'h0 && o_autostart)
      else $error("start-up write not acknowledged");
   a_startup_off: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_index == OBJ_STARTUP && rx_sub == 8'h00 &&
      rx_cmd == CMD_DNLOAD_4B && rx_data == 32'h0
      |=> !o_autostart)
      else $error("start-up disable ignored");
   a_startup_read: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_index == OBJ_STARTUP && rx_sub == 8'h00 &&
      rx_cmd == CMD_UPLOAD_REQ
      |=> o_tx_frame.data[63:32] ==
          {24'h0, $past(o_autostart) ? 8'h08 : 8'h00})
      else $error("start-up setting read back wrong");
   a_reply_id: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      o_tx_valid |-> o_tx_frame.id == 11'h580 + {4'h0, i_node_id})
      else $error("reply identifier wrong");
   a_reply_echo: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken |=> o_tx_valid && o_tx_frame.dlc == 4'h8 &&
      o_tx_frame.data[31:8] == $past(i_rx_frame.data[31:8]))
      else $error("reply does not echo the object");
   a_no_pdo_pre: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      state == ST_BOOT || !o_operational |-> !o_pdo_enable)
      else $error("process data enabled before run");
   a_boot_ignore: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      state == ST_BOOT && for_me |=> !o_tx_valid)
      else $error("request served during boot");
   a_boot_run: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      state == ST_BOOT && i_boot_done |=> o_operational == $past(o_autostart))
      else $error("start-up setting not applied after boot");
   a_reset_vol: assert property (
      @(posedge i_clk)
      !i_resetn |=> !o_autostart && !o_operational)
      else $error("start-up setting survived reset");
   a_float_ans: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_cmd == 8'h40 &&
      rx_index == 16'h6130 && rx_sub == 8'h01
      |=> o_tx_frame.data[7:0] == 8'h43 &&
          o_tx_frame.data[63:32] == (i_msb_first ?
          {$past(i_chan1.pv_float[7:0]), $past(i_chan1.pv_float[15:8]),
          $past(i_chan1.pv_float[23:16]), $past(i_chan1.pv_float[31:24])} :
          $past(i_chan1.pv_float)))
      else $error("float upload reply wrong");
   a_field_zero: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_cmd == 8'h40 && rx_index == 16'h7100 && sub_ok
      |=> o_tx_frame.data[63:48] == 16'h0000 &&
          o_tx_frame.data[7:0] == 8'h43)
      else $error("field value reply malformed");
   a_field_raw: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_cmd == 8'h40 && rx_index == 16'h7100 &&
      rx_sub == 8'h01 && !i_msb_first
      |=> o_tx_frame.data[47:32] == $past(i_chan1.fv_int16))
      else $error("field value altered");
   a_int16_pair: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_cmd == 8'h40 && rx_index == 16'h7130 && sub_ok
      |=> o_tx_frame.data[63:48] == 16'h0000 &&
          o_tx_frame.data[7:0] == 8'h43)
      else $error("int16 process value reply malformed");
   a_shift_none: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_dec_shift == 3'h0 && !i_clamp_en |-> shaped32 == chan.pv_int)
      else $error("integer value altered without shift");
   a_clamp_hold: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_clamp_en && i_clamp_min <= i_clamp_max |->
      $signed(shaped32) >= i_clamp_min && $signed(shaped32) <= i_clamp_max)
      else $error("clamp bounds exceeded");
   a_unknown_abort: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_index == 16'h1234
      |=> o_tx_valid && o_tx_frame.data[7:0] == 8'h80)
      else $error("unknown object not aborted");
   a_bad_sub: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      req_taken && rx_index == 16'h6130 &&
      rx_sub != 8'h01 && rx_sub != 8'h02
      |=> o_tx_frame.data[7:0] == 8'h80 &&
          o_tx_frame.data[63:32] == 32'h0609_0011)
      else $error("missing sub-index not aborted");
   a_send_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame))
      else $error("reply dropped before taken");
   a_send_done: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_tx_valid && i_tx_ready |=> !o_tx_valid)
      else $error("reply repeated after hand-off");
endmodule // sdo_responder

// ===== tb/sdo_master_model.sv
// Network master model issuing expedited object access requests
`timescale 1ns/100ps
module sdo_master_model
   import sdo_pkg::*;
(
   // Clock
   input  wire logic       i_clk,
   // Reply from the node
   input  wire can_frame_s i_tx_frame,
   input  wire logic       i_tx_valid,
   // Request to the node
   output can_frame_s      o_rx_frame,
   output logic            o_rx_valid,
   output logic            o_tx_ready
);
   initial begin
      o_rx_frame = '0;
      o_rx_valid = 1'b0;
      o_tx_ready = 1'b0;
   end

   // One request, reply taken after stall cycles; first and taken frames
   task automatic send(input logic [10:0] id, input logic [63:0] data,
      input int stall, output logic got, output can_frame_s rsp,
      output can_frame_s first, output int lat);
      int n;
      got = 1'b0;
      rsp = '0;
      first = '0;
      n = 0;
      @(negedge i_clk);
      o_rx_frame = {id, 4'h8, data};
      o_rx_valid = 1'b1;
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      // Released lines do not keep showing the request
      o_rx_frame = ~o_rx_frame;
      while (i_tx_valid !== 1'b1 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      lat = n;
      if (i_tx_valid === 1'b1) begin
         first = i_tx_frame;
         repeat (stall) @(negedge i_clk);
         o_tx_ready = 1'b1;
         @(posedge i_clk);
         rsp = i_tx_frame;
         got = 1'b1;
         @(negedge i_clk);
         o_tx_ready = 1'b0;
      end
   endtask
endmodule // sdo_master_model

// ===== tb/tb.sv
// Self-checking bench of the object access responder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("[ERR] %s exp %h got %h", nm, (e), (g)); \
   end \
end
module tb
   import sdo_pkg::*;
;
   logic               clk;
   logic               resetn;
   logic         [6:0] node;
   logic               msb;
   logic         [2:0] dec;
   logic               clamp;
   logic signed [31:0] cmin;
   logic signed [31:0] cmax;
   logic               boot;
   chan_value_s        ch1;
   chan_value_s        ch2;
   can_frame_s         rx_frame;
   logic               rx_valid;
   can_frame_s         tx_frame;
   logic               tx_valid;
   logic               tx_ready;
   logic               autostart;
   logic               oper;
   logic               pdo_en;
   logic        [10:0] rxid;
   int                 n_errors;
   int                 total_checks;
   int                 stall;

   assign rxid = COB_RX_BASE + {4'h0, node};

   initial clk = 1'b0;
   always #20 clk = ~clk;

   sdo_responder #(.HAS_SECONDARY(1'b1)) dut (.i_clk(clk), .i_resetn(resetn),
      .i_node_id(node), .i_msb_first(msb), .i_dec_shift(dec),
      .i_clamp_en(clamp), .i_clamp_min(cmin), .i_clamp_max(cmax),
      .i_boot_done(boot), .i_chan1(ch1), .i_chan2(ch2),
      .i_rx_frame(rx_frame), .i_rx_valid(rx_valid), .o_tx_frame(tx_frame),
      .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_autostart(autostart),
      .o_operational(oper), .o_pdo_enable(pdo_en));

   sdo_master_model m (.i_clk(clk), .i_tx_frame(tx_frame),
      .i_tx_valid(tx_valid), .o_rx_frame(rx_frame), .o_rx_valid(rx_valid),
      .o_tx_ready(tx_ready));

   function automatic logic [63:0] mk(input logic [7:0] cmd,
      input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
      return {d, sub, idx[15:8], idx[7:0], cmd};
   endfunction

   // Data bytes 4..7 as expected in the chosen byte order
   function automatic logic [31:0] ord(input logic [31:0] v,
      input logic two, input logic hi);
      if (two)
         return hi ? {16'h0, v[7:0], v[15:8]} : {16'h0, v[15:0]};
      return hi ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
   endfunction

   function automatic logic [31:0] sat16(input logic signed [31:0] x);
      if (x > 32'sd32767)
         return 32'h0000_7FFF;
      if (x < -32'sd32768)
         return 32'h0000_8000;
      return {16'h0, x[15:0]};
   endfunction

   task automatic req(input logic [10:0] id, input logic [63:0] d,
      input logic exp_got, input logic [63:0] exp_d, input string nm);
      logic       got;
      can_frame_s r;
      can_frame_s f;
      int         lat;
      m.send(id, d, stall, got, r, f, lat);
      `CHK(nm, exp_got, got)
      if (exp_got) begin
         `CHK(nm, {COB_TX_BASE + {4'h0, node}, 4'h8, exp_d}, r)
         `CHK(nm, f, r)
         `CHK(nm, 0, lat)
      end
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] v, input logic two, input string nm);
      req(rxid, mk(CMD_UPLOAD_REQ, idx, sub, 32'h0), 1'b1,
         mk(CMD_UPLOAD_4B, idx, sub, ord(v, two, msb)), nm);
   endtask

   task automatic wr(input logic [7:0] v, input logic [63:0] exp_d);
      req(rxid, mk(CMD_DNLOAD_4B, OBJ_STARTUP, 8'h00, {24'h0, v}), 1'b1,
         exp_d, "startup write");
   endtask

   // Firmware restart without reset; operational follows the setting
   task automatic reboot(input logic exp_op);
      boot = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("oper", 1'b0, oper)
      boot = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("oper", exp_op, oper)
      `CHK("pdo", exp_op, pdo_en)
   endtask

   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      results();
   end

   initial begin
      logic [15:0] obj [4];
      logic [31:0] v;
      logic [7:0]  ac_cmd [4];
      logic [15:0] ac_idx [4];
      logic [7:0]  ac_sub [4];
      logic [31:0] ac_code [4];
      chan_value_s c;
      obj = '{OBJ_PV_FLOAT, OBJ_PV_INT16, OBJ_PV_INT32, OBJ_FV_INT16};
      ac_cmd = '{CMD_UPLOAD_REQ, CMD_UPLOAD_REQ, CMD_DNLOAD_4B, 8'hE0};
      ac_idx = '{16'h1234, OBJ_PV_FLOAT, OBJ_PV_FLOAT, OBJ_STARTUP};
      ac_sub = '{8'h01, 8'h03, SUB_PRIMARY, 8'h00};
      ac_code = '{ABORT_NO_OBJ, ABORT_NO_SUB, ABORT_READ_ONLY, ABORT_BAD_CMD};
      n_errors = 0;
      total_checks = 0;
      stall = 0;
      resetn = 1'b0;
      node = 7'h05;
      msb = 1'b0;
      dec = 3'h0;
      clamp = 1'b0;
      cmin = 32'sh0;
      cmax = 32'sh3E8;
      boot = 1'b0;
      ch1 = '{32'h469C_4000, 32'hFFFF_FFF3, 16'hFFF3};
      ch2 = '{32'h42FA_0000, 32'h0001_2345, 16'h4E20};
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      `CHK("autostart", 1'b0, autostart)
      `CHK("pdo", 1'b0, pdo_en)
      req(rxid, mk(CMD_UPLOAD_REQ, OBJ_PV_FLOAT, SUB_PRIMARY, 32'h0),
         1'b0, 64'h0, "in boot");
      req(rxid, mk(CMD_UPLOAD_REQ, OBJ_STARTUP, 8'h0, 32'h0), 1'b0, 64'h0, "boot");
      boot = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("oper", 1'b0, oper)
      `CHK("pdo", 1'b0, pdo_en)
      wr(STARTUP_AUTO, mk(CMD_DNLOAD_ACK, OBJ_STARTUP, 8'h0, 32'h0));
      `CHK("autostart", 1'b1, autostart)
      rd(OBJ_STARTUP, 8'h00, 32'h8, 1'b0, "startup read");
      wr(STARTUP_OFF, mk(CMD_DNLOAD_ACK, OBJ_STARTUP, 8'h0, 32'h0));
      `CHK("autostart", 1'b0, autostart)
      wr(8'h05, mk(CMD_ABORT, OBJ_STARTUP, 8'h0, ABORT_BAD_VAL));
      for (int o = 0; o < 2; o++) begin
         msb = o[0];
         stall = 3 * o;
         for (int s = 1; s <= 2; s++) begin
            c = (s == 1) ? ch1 : ch2;
            for (int k = 0; k < 4; k++) begin
               v = (k == 0) ? c.pv_float : (k == 1) ? sat16(c.pv_int)
                  : (k == 2) ? c.pv_int : {16'h0, c.fv_int16};
               rd(obj[k], s[7:0], v, k[0], "value");
            end
         end
      end
      msb = 1'b0;
      stall = 1;
      ch1.pv_int = 32'h0000_0003;
      dec = 3'h2;
      clamp = 1'b1;
      rd(OBJ_PV_INT32, SUB_PRIMARY, 32'h12C, 1'b0, "shift32");
      rd(OBJ_PV_INT16, SUB_PRIMARY, 32'h12C, 1'b1, "shift16");
      ch1.pv_int = 32'hFFFF_FFF3;
      rd(OBJ_PV_INT32, SUB_PRIMARY, 32'h0, 1'b0, "clamp low");
      rd(OBJ_FV_INT16, SUB_PRIMARY, 32'hFFF3, 1'b1, "field raw");
      dec = 3'h0;
      ch1.pv_int = 32'h0000_1388;
      rd(OBJ_PV_INT32, SUB_PRIMARY, 32'h3E8, 1'b0, "clamp high");
      for (int i = 0; i < 4; i++)
         req(rxid, mk(ac_cmd[i], ac_idx[i], ac_sub[i], 32'h0), 1'b1, mk(CMD_ABORT, ac_idx[i], ac_sub[i], ac_code[i]), "abort");
      req(rxid + 11'h1, mk(CMD_UPLOAD_REQ, OBJ_PV_FLOAT, 8'h1, 32'h0), 1'b0, 64'h0, "other id");
      wr(STARTUP_AUTO, mk(CMD_DNLOAD_ACK, OBJ_STARTUP, 8'h0, 32'h0));
      reboot(1'b1);
      wr(STARTUP_OFF, mk(CMD_DNLOAD_ACK, OBJ_STARTUP, 8'h0, 32'h0));
      reboot(1'b0);
      wr(STARTUP_AUTO, mk(CMD_DNLOAD_ACK, OBJ_STARTUP, 8'h0, 32'h0));
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("autostart", 1'b0, autostart)
      `CHK("oper", 1'b0, oper)
      results();
   end
endmodule // tb
